// [core/uart_serial_ctrl.sv]
`timescale 1ns/1ps

// Plain FIFO; DEPTH must be a power of two
module fifo_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];  // Storage, no reset needed
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;
  assign in_ready = cnt_reg < (AW+1)'(DEPTH);
  assign out_valid = cnt_reg != '0;
  assign out_data = mem[rp_reg];
  assign count = cnt_reg;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  // Storage write
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wp_reg] <= in_data;
  end
  // Pointers and fill; flush wins over traffic
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end
    else if (flush)
    begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      wp_reg <= wp_reg + AW'(push);
      rp_reg <= rp_reg + AW'(pop);
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : fifo_buf

module uart_serial_ctrl (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cs,
  input wire logic rd,
  input wire logic wr,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  output logic rdata_oe_n,
  output logic intr,
  output logic baud_out,
  input wire uart_pkg::rx_char_type rx_char,
  input wire logic rx_char_valid,
  output logic rx_char_ready,
  output logic [7:0] tx_char,
  output logic tx_char_valid,
  input wire logic tx_char_ready,
  input wire logic tx_shift_busy,
  input wire logic rclk,
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic ri_n,
  input wire logic dcd_n,
  output logic dtr_n,
  output logic rts_n,
  output logic aux_output_one_n,
  output logic aux_output_two_n
);
  import uart_pkg::*;
  logic [7:0] lcr_reg, ier_reg, mcr_reg, scratch_storage_reg;
  logic [15:0] div_reg, div_next;  // Divisor latch pair
  logic [15:0] baud_cnt_reg;
  logic fifo_en_reg;
  logic [1:0] trig_sel_reg;
  logic [4:0] sync1_reg, sync2_reg;  // {rclk, dcd, ri, dsr, cts}
  logic rclk_d_reg;
  modem_type mdm_now, mdm_prev_reg;
  logic [3:0] delta_reg;  // {dcd, ring, dsr, cts} change flags
  logic [3:0] lsr_err_reg;  // {break, frame, parity, overrun}
  logic [4:0] err_cnt_reg;  // Error characters held in receive FIFO
  logic [9:0] to_cnt_reg;
  logic timeout_reg;
  logic tx_holding_empty_flag_irq_reg, tx_holding_empty_flag_prev_reg, two_seen_reg, fen_chg_reg;
  logic [7:0] dly_cnt_reg;
  logic dly_run_reg;
  logic wr_s, rd_s, divisor_access_bit, loop;
  logic wr_dll, wr_dlm, wr_thr, rd_rbr, rd_iir, rd_lsr, rd_msr;
  logic baud_tick, rclk_tick;
  logic rx_push, rx_pop, rx_in_ready, tx_in_ready, tx_out_valid, tx_pop;
  rx_char_type rx_head;
  logic [4:0] rx_cnt, tx_cnt, rx_cnt_next;
  logic [7:0] tx_head;
  logic rx_avail, tx_holding_empty_flag_cond, temt;
  logic line_int, rxd_int, to_int, tx_holding_empty_flag_int, mdm_int;
  logic [3:0] iir_id;
  logic [7:0] lsr_val, rd_mux;

  // Character length in bits: start, data, parity, stops
  function automatic logic [3:0] char_bits(input logic [7:0] lcr);
    return 4'h7 + {2'b00, lcr[1:0]} + {3'b000, lcr[3]} + {3'b000, lcr[2]};
  endfunction : char_bits

  // Host strobes, all synchronous single-cycle pulses
  assign wr_s = cs && wr;
  assign rd_s = cs && rd;
  assign divisor_access_bit = lcr_reg[DIVISOR_ACCESS_BIT_BIT];
  assign loop = mcr_reg[LOOP_BIT];
  assign wr_dll = wr_s && addr == ADDR_DATA && divisor_access_bit;
  assign wr_dlm = wr_s && addr == ADDR_IER && divisor_access_bit;
  assign wr_thr = wr_s && addr == ADDR_DATA && !divisor_access_bit;
  assign rd_rbr = rd_s && addr == ADDR_DATA && !divisor_access_bit;
  assign rd_iir = rd_s && addr == ADDR_IIR;
  assign rd_lsr = rd_s && addr == ADDR_LSR;
  assign rd_msr = rd_s && addr == ADDR_MSR;
  assign div_next = {wr_dlm ? wdata : div_reg[15:8], wr_dll ? wdata : div_reg[7:0]};

  // Control registers written by the host
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lcr_reg <= BYTE_RESET;
      ier_reg <= BYTE_RESET;
      mcr_reg <= BYTE_RESET;
      scratch_storage_reg <= BYTE_RESET;
      div_reg <= DIV_RESET;
      fifo_en_reg <= 1'b0;
      trig_sel_reg <= 2'b00;
      fen_chg_reg <= 1'b0;
    end
    else
    begin
      div_reg <= div_next;
      fen_chg_reg <= wr_s && addr == ADDR_IIR && wdata[0] != fifo_en_reg;
      if (wr_s)
      begin
        unique case (addr)
          ADDR_IER: if (!divisor_access_bit) ier_reg <= wdata;
          ADDR_IIR:
          begin
            fifo_en_reg <= wdata[0];
            trig_sel_reg <= wdata[7:6];
          end
          ADDR_LCR: lcr_reg <= wdata;
          ADDR_MCR: mcr_reg <= {3'b000, wdata[4:0]};
          ADDR_SCR: scratch_storage_reg <= wdata;
          default: ;  // Data, line and modem status take no store
        endcase
      end
    end
  end

  // Baud divider; a divisor write restarts the count at once
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      baud_cnt_reg <= DIV_RESET;
    else if (wr_dll || wr_dlm)
      baud_cnt_reg <= div_next;
    else if (baud_cnt_reg <= 16'h0001)
      baud_cnt_reg <= div_reg;
    else
      baud_cnt_reg <= baud_cnt_reg - 16'h0001;
  end
  assign baud_tick = baud_cnt_reg == 16'h0001;

  // Pin synchronisers, then edge and level use on the second stage only
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_reg <= 5'h0F;
      sync2_reg <= 5'h0F;
      rclk_d_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= {rclk, dcd_n, ri_n, dsr_n, cts_n};
      sync2_reg <= sync1_reg;
      rclk_d_reg <= sync2_reg[4];
    end
  end
  assign rclk_tick = sync2_reg[4] && !rclk_d_reg;

  // Loopback feeds the control bits back as handshake inputs
  always_comb
  begin
    if (loop)
      mdm_now = '{dcd: mcr_reg[3], ri: mcr_reg[2], dsr: mcr_reg[0], cts: mcr_reg[1]};
    else
      mdm_now = modem_type'(~sync2_reg[3:0]);
  end

  // Change flags; a new change wins over the clearing read
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mdm_prev_reg <= '0;
      delta_reg <= 4'h0;
    end
    else
    begin
      mdm_prev_reg <= mdm_now;
      delta_reg <= (rd_msr ? 4'h0 : delta_reg)
        | {mdm_now.dcd ^ mdm_prev_reg.dcd,
           mdm_prev_reg.ri && !mdm_now.ri,
           mdm_now.dsr ^ mdm_prev_reg.dsr,
           mdm_now.cts ^ mdm_prev_reg.cts};
    end
  end

  // Receive path, ready taken from the next fill count so it can be a flop
  assign rx_push = rx_char_valid && rx_char_ready && rx_in_ready;
  assign rx_pop = rd_rbr && rx_cnt != 5'h00;
  assign rx_cnt_next = rx_cnt + 5'(rx_push) - 5'(rx_pop);
  fifo_buf #(.WIDTH($bits(rx_char_type)), .DEPTH(FIFO_DEPTH)) rx_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .flush(1'b0),
    .in_data(rx_char),
    .in_valid(rx_char_valid && rx_char_ready),
    .in_ready(rx_in_ready),
    .out_data(rx_head),
    .out_valid(),
    .out_ready(rx_pop),
    .count(rx_cnt)
  );

  // Error flags and count of error characters still held
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_char_ready <= 1'b0;
      lsr_err_reg <= 4'h0;
      err_cnt_reg <= 5'h00;
    end
    else
    begin
      rx_char_ready <= rx_cnt_next < 5'(FIFO_DEPTH);
      lsr_err_reg <= (rd_lsr ? 4'h0 : lsr_err_reg)
        | {rx_push && rx_char.brk, rx_push && rx_char.frame,
           rx_push && rx_char.parity, rx_char_valid && !rx_char_ready};
      err_cnt_reg <= err_cnt_reg
        + 5'(rx_push && (rx_char.brk || rx_char.frame || rx_char.parity))
        - 5'(rx_pop && (rx_head.brk || rx_head.frame || rx_head.parity));
    end
  end

  // Timeout timer in receive clock ticks; any traffic restarts it
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      to_cnt_reg <= 10'h000;
      timeout_reg <= 1'b0;
    end
    else if (rx_push || rx_pop || rx_cnt == 5'h00 || !fifo_en_reg)
    begin
      to_cnt_reg <= 10'h000;
      timeout_reg <= 1'b0;
    end
    else if (to_cnt_reg == 10'(char_bits(lcr_reg) * TIMEOUT_TICKS))
      timeout_reg <= 1'b1;
    else
      to_cnt_reg <= to_cnt_reg + 10'(rclk_tick);
  end

  // Transmit path with a registered output stage
  fifo_buf #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) tx_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .flush(1'b0),
    .in_data(wdata),
    .in_valid(wr_thr),
    .in_ready(tx_in_ready),
    .out_data(tx_head),
    .out_valid(tx_out_valid),
    .out_ready(tx_pop),
    .count(tx_cnt)
  );
  assign tx_pop = tx_out_valid && (!tx_char_valid || tx_char_ready);

  // Output stage towards the transmit shifter
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_char_valid <= 1'b0;
      tx_char <= BYTE_RESET;
    end
    else if (tx_pop)
    begin
      tx_char_valid <= 1'b1;
      tx_char <= tx_head;
    end
    else if (tx_char_ready)
      tx_char_valid <= 1'b0;
  end

  // Transmit trigger and empty conditions, and the receive trigger level
  assign tx_holding_empty_flag_cond = tx_cnt < (ier_reg[ENH_BIT] ? TX_TRIG_ENH : TX_TRIG_BASE);
  assign temt = tx_cnt == 5'h00 && !tx_char_valid && !tx_shift_busy;
  assign rx_avail = rx_cnt >= (fifo_en_reg ? RX_TRIG[trig_sel_reg] : 5'h01);

  // Transmit interrupt with optional one-character hold-off
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_holding_empty_flag_irq_reg <= 1'b0;
      tx_holding_empty_flag_prev_reg <= 1'b1;
      two_seen_reg <= 1'b0;
      dly_run_reg <= 1'b0;
      dly_cnt_reg <= 8'h00;
    end
    else
    begin
      tx_holding_empty_flag_prev_reg <= tx_holding_empty_flag_cond;
      if (tx_holding_empty_flag_cond && !tx_holding_empty_flag_prev_reg)
        two_seen_reg <= 1'b0;
      else if (tx_cnt >= 5'h02)
        two_seen_reg <= 1'b1;
      if (fen_chg_reg)
      begin
        tx_holding_empty_flag_irq_reg <= tx_holding_empty_flag_cond;
        dly_run_reg <= 1'b0;
      end
      else if (tx_holding_empty_flag_cond && !tx_holding_empty_flag_prev_reg && !two_seen_reg && fifo_en_reg)
      begin
        dly_run_reg <= 1'b1;
        dly_cnt_reg <= 8'((char_bits(lcr_reg) - 4'h1) * TICKS_PER_BIT);
      end
      else if (tx_holding_empty_flag_cond && !tx_holding_empty_flag_prev_reg)
        tx_holding_empty_flag_irq_reg <= 1'b1;
      else if (dly_run_reg && dly_cnt_reg == 8'h00)
      begin
        dly_run_reg <= 1'b0;
        tx_holding_empty_flag_irq_reg <= tx_holding_empty_flag_cond;
      end
      else if (!tx_holding_empty_flag_cond || (rd_iir && iir_id == IIR_TX_HOLDING_EMPTY_FLAG))
        tx_holding_empty_flag_irq_reg <= 1'b0;
      if (dly_run_reg && dly_cnt_reg != 8'h00)
        dly_cnt_reg <= dly_cnt_reg - 8'(baud_tick);
    end
  end

  // Source priority; cleared enables leave that direction polled
  assign line_int = ier_reg[2] && lsr_err_reg != 4'h0;
  assign rxd_int = ier_reg[0] && rx_avail;
  assign to_int = ier_reg[0] && timeout_reg;
  assign tx_holding_empty_flag_int = ier_reg[1] && tx_holding_empty_flag_irq_reg;
  assign mdm_int = ier_reg[3] && delta_reg != 4'h0;
  always_comb
  begin
    if (line_int)
      iir_id = IIR_LINE;
    else if (rxd_int)
      iir_id = IIR_RXDATA;
    else if (to_int)
      iir_id = IIR_TIMEOUT;
    else if (tx_holding_empty_flag_int)
      iir_id = IIR_TX_HOLDING_EMPTY_FLAG;
    else if (mdm_int)
      iir_id = IIR_MODEM;
    else
      iir_id = IIR_NONE;
  end

  // Line status as seen by a polling host
  assign lsr_val = {fifo_en_reg && err_cnt_reg != 5'h00, temt, tx_holding_empty_flag_cond,
                    lsr_err_reg, rx_cnt != 5'h00};

  // Read selection
  always_comb
  begin
    unique case (addr)
      ADDR_DATA: rd_mux = divisor_access_bit ? div_reg[7:0] : rx_head.data;
      ADDR_IER: rd_mux = divisor_access_bit ? div_reg[15:8] : ier_reg;
      ADDR_IIR: rd_mux = {{2{fifo_en_reg}}, 2'b00, iir_id};
      ADDR_LCR: rd_mux = lcr_reg;
      ADDR_MCR: rd_mux = mcr_reg;
      ADDR_LSR: rd_mux = lsr_val;
      ADDR_MSR: rd_mux = {mdm_now, delta_reg};
      ADDR_SCR: rd_mux = scratch_storage_reg;
    endcase
  end

  // Registered pin side: read data, interrupt, modem outputs
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata <= BYTE_RESET;
      rdata_oe_n <= 1'b1;
      intr <= 1'b0;
      baud_out <= 1'b0;
      {aux_output_two_n, aux_output_one_n, rts_n, dtr_n} <= 4'hF;
    end
    else
    begin
      if (rd_s)
        rdata <= rd_mux;
      rdata_oe_n <= !rd_s;
      intr <= iir_id != IIR_NONE;
      baud_out <= baud_tick;
      {aux_output_two_n, aux_output_one_n, rts_n, dtr_n} <= loop ? 4'hF : ~mcr_reg[3:0];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_scr_write;
    wr_s && addr == ADDR_SCR;
  endsequence
  sequence s_div3_run;
    baud_tick && div_reg == 16'h0003 && !wr_dll && !wr_dlm ##1 (!wr_dll && !wr_dlm)[*2];
  endsequence
  a_cts_change_flag: assert property (mdm_now.cts != mdm_prev_reg.cts |=> delta_reg[0])
    else $error("cts change not flagged");
  a_ring_edge_flag: assert property (mdm_prev_reg.ri && !mdm_now.ri |=> delta_reg[2])
    else $error("ring edge not flagged");
  a_status_inputs: assert property (rd_msr && !loop |=> rdata[7:4] == ~$past(sync2_reg[3:0]))
    else $error("status does not show inverted inputs");
  a_loop_mirror: assert property (rd_msr && loop |=> rdata[4] == $past(mcr_reg[1])
    && rdata[5] == $past(mcr_reg[0])) else $error("loopback mirror wrong");
  // The host leaves one idle cycle between accesses, so the read lands two cycles on
  a_scratch_readback: assert property (s_scr_write ##1 !wr_s
    ##1 (rd_s && addr == ADDR_SCR && !wr_s)
    |=> rdata == $past(wdata, 3)) else $error("scratch readback wrong");
  a_baud_period: assert property (s_div3_run |=> baud_tick)
    else $error("baud tick period wrong");
  a_divisor_reload: assert property (wr_dll |=> baud_cnt_reg == div_reg)
    else $error("divisor write did not reload");
  a_line_priority: assert property (rd_iir && line_int |=> rdata[3:0] == IIR_LINE)
    else $error("line status not first");
  a_data_ready: assert property (rd_lsr |=> rdata[0] == ($past(rx_cnt) != 5'h00))
    else $error("data ready wrong");
  a_msr_clear: assert property (rd_msr && mdm_now == mdm_prev_reg |=> delta_reg == 4'h0)
    else $error("change flags not cleared");
  a_modem_request: assert property (ier_reg[3] && delta_reg != 4'h0 |=> intr)
    else $error("modem change gave no interrupt");
endmodule : uart_serial_ctrl

// [core/uart_pkg.sv]
package uart_pkg;
  localparam logic [2:0] ADDR_DATA = 3'h0;  // Data or divisor low
  localparam logic [2:0] ADDR_IER = 3'h1;  // Enables or divisor high
  localparam logic [2:0] ADDR_IIR = 3'h2;  // Ident on read, FIFO control on write
  localparam logic [2:0] ADDR_LCR = 3'h3;
  localparam logic [2:0] ADDR_MCR = 3'h4;
  localparam logic [2:0] ADDR_LSR = 3'h5;
  localparam logic [2:0] ADDR_MSR = 3'h6;
  localparam logic [2:0] ADDR_SCR = 3'h7;
  localparam int DIVISOR_ACCESS_BIT_BIT = 7;
  localparam int LOOP_BIT = 4;
  localparam int ENH_BIT = 5;  // Enhanced transmit trigger enable
  localparam logic [3:0] IIR_NONE = 4'h1;
  localparam logic [3:0] IIR_LINE = 4'h6;
  localparam logic [3:0] IIR_RXDATA = 4'h4;
  localparam logic [3:0] IIR_TIMEOUT = 4'hC;
  localparam logic [3:0] IIR_TX_HOLDING_EMPTY_FLAG = 4'h2;
  localparam logic [3:0] IIR_MODEM = 4'h0;
  localparam int FIFO_DEPTH = 16;
  localparam logic [4:0] RX_TRIG [4] = '{5'h01, 5'h04, 5'h08, 5'h0E};
  localparam logic [4:0] TX_TRIG_BASE = 5'h01;
  localparam logic [4:0] TX_TRIG_ENH = 5'h08;
  localparam logic [7:0] TICKS_PER_BIT = 8'h10;
  localparam logic [9:0] TIMEOUT_TICKS = 10'h040;  // Four characters at 16 ticks per bit
  localparam logic [15:0] DIV_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  typedef struct packed {
    logic brk;
    logic frame;
    logic parity;
    logic [7:0] data;
  } rx_char_type;
  typedef struct packed {
    logic dcd;
    logic ri;
    logic dsr;
    logic cts;
  } modem_type;
endpackage : uart_pkg

// [sim/modem_peer.sv]
`timescale 1ns/1ps

// Far side of the block: handshake pins, receive shifter, transmit shifter, receive clock
module modem_peer
  import uart_pkg::*;
(
  input wire logic clk,
  output uart_pkg::rx_char_type rx_char,
  output logic rx_char_valid,
  input wire logic rx_char_ready,
  input wire logic [7:0] tx_char,
  input wire logic tx_char_valid,
  output logic tx_char_ready,
  output logic tx_shift_busy,
  output logic rclk,
  output uart_pkg::modem_type pins
);
  logic stall = 1'b0;  // Holds off the transmit shifter to back up the FIFO
  logic rclk_on = 1'b0;  // Receive clock runs only while rclk_on is set, which the bench does for the timeout test with no frame sent
  logic [7:0] got_q[$];  // Characters taken from the transmit side
  int busy_cnt = 0;  // Remaining cycles of the shifter sending a character

  initial
  begin
    rx_char = '0;
    rx_char_valid = 1'b0;
    pins = '1;  // All handshake inputs inactive
    rclk = 1'b0;
  end

  // Off-edge activity: receive clock and an idle pattern so nothing stale looks valid
  always @(negedge clk)
  begin
    if (rclk_on)
      rclk = ~rclk;
    if (!rx_char_valid)
      rx_char = ~rx_char;
  end

  // Transmit shifter accepts unless stalled, then stays busy a while
  assign tx_char_ready = !stall;
  assign tx_shift_busy = (busy_cnt != 0);
  always @(posedge clk)
  begin
    if (tx_char_valid && tx_char_ready)
    begin
      got_q.push_back(tx_char);
      busy_cnt <= 20;
    end
    else if (busy_cnt > 0)
      busy_cnt <= busy_cnt - 1;
  end

  // Offer one character, hold it until the block is ready, then release
  task send(input rx_char_type c);
    @(posedge clk);
    #1;
    rx_char = c;
    rx_char_valid = 1'b1;
    for (int i = 0; i < 200 && !rx_char_ready; i++)
    begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
    rx_char_valid = 1'b0;
  endtask : send

  // Move the handshake pins after a clock edge
  task set_pins(input modem_type p);
    @(posedge clk);
    #1;
    pins = p;
  endtask : set_pins
endmodule : modem_peer

// [sim/tb_uart_serial_ctrl.sv]
`timescale 1ns/1ps

module tb_uart_serial_ctrl;
  import uart_pkg::*;
  logic clk, rst_n, cs, rd, wr, rdata_oe_n, intr, baud_out;
  logic rx_char_valid, rx_char_ready, tx_char_valid, tx_char_ready, tx_shift_busy, rclk;
  logic dtr_n, rts_n, aux_output_one_n, aux_output_two_n;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, tx_char, d;
  logic [3:0] prev, dl;  // Previous pin pattern and expected change flags
  rx_char_type rx_char;
  modem_type pins;
  int error_cnt = 0;
  int n_compared = 0;
  int n;
  // Pin walk: each handshake input changes both ways
  localparam logic [3:0] PIN_SEQ [8] = '{4'hE, 4'hC, 4'h8, 4'h0, 4'h4, 4'h5, 4'hD, 4'hF};

  uart_serial_ctrl u_uart_serial_ctrl (.clk(clk), .rst_n(rst_n), .cs(cs), .rd(rd), .wr(wr),
    .addr(addr), .wdata(wdata), .rdata(rdata), .rdata_oe_n(rdata_oe_n), .intr(intr),
    .baud_out(baud_out), .rx_char(rx_char), .rx_char_valid(rx_char_valid),
    .rx_char_ready(rx_char_ready), .tx_char(tx_char), .tx_char_valid(tx_char_valid),
    .tx_char_ready(tx_char_ready), .tx_shift_busy(tx_shift_busy), .rclk(rclk),
    .cts_n(pins.cts), .dsr_n(pins.dsr), .ri_n(pins.ri), .dcd_n(pins.dcd), .dtr_n(dtr_n),
    .rts_n(rts_n), .aux_output_one_n(aux_output_one_n), .aux_output_two_n(aux_output_two_n));

  modem_peer u_modem_peer (.clk(clk), .rx_char(rx_char), .rx_char_valid(rx_char_valid),
    .rx_char_ready(rx_char_ready), .tx_char(tx_char), .tx_char_valid(tx_char_valid),
    .tx_char_ready(tx_char_ready), .tx_shift_busy(tx_shift_busy), .rclk(rclk), .pins(pins));

  // 40 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task report_and_stop;
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop

  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task chk_bit(input string nm, input logic e, input logic g);
    n_compared++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit

  // One cycle, landing just after the edge like every input change but rclk and the idle pattern
  task tick;
    @(posedge clk);
    #1;
  endtask : tick

  task wr_reg(input logic [2:0] a, input logic [7:0] v);
    tick();
    cs = 1'b1;
    wr = 1'b1;
    addr = a;
    wdata = v;
    tick();
    cs = 1'b0;
    wr = 1'b0;
  endtask : wr_reg

  // Strobe is one cycle; data is registered on the taking edge
  task rd_reg(input logic [2:0] a, output logic [7:0] v);
    tick();
    cs = 1'b1;
    rd = 1'b1;
    addr = a;
    tick();
    cs = 1'b0;
    rd = 1'b0;
    v = rdata;
  endtask : rd_reg

  task rd_chk(input string nm, input logic [2:0] a, input logic [7:0] e);
    rd_reg(a, d);
    chk(nm, e, d);
  endtask : rd_chk

  // Bounded wait for the interrupt level, then compare it
  task wait_intr(input logic e, input int lim);
    for (int i = 0; i < lim && intr !== e; i++)
      tick();
    chk_bit("intr_wait", e, intr);
  endtask : wait_intr

  // Cycles between two baud ticks
  task baud_gap(output int g);
    for (int i = 0; i < 600 && baud_out !== 1'b1; i++)
      tick();
    g = 0;
    do
    begin
      tick();
      g++;
    end while (baud_out !== 1'b1 && g < 600);
  endtask : baud_gap

  // Watchdog well past the expected run length
  initial
  begin
    #(40000 * 25);
    error_cnt++;
    report_and_stop();
  end

  initial
  begin
    rst_n = 1'b0;
    cs = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    repeat (10) @(posedge clk);
    #1;
    rst_n = 1'b1;
    chk_bit("intr_rst", 1'b0, intr);
    rd_chk("scr_rst", ADDR_SCR, 8'h00);
    rd_chk("msr_rst", ADDR_MSR, 8'h00);
    chk_bit("oe_read", 1'b0, rdata_oe_n);
    wr_reg(ADDR_SCR, 8'hA5);
    rd_chk("scr", ADDR_SCR, 8'hA5);
    wr_reg(ADDR_SCR, 8'h5A);
    rd_chk("scr", ADDR_SCR, 8'h5A);
    // Divisor programmed with the access bit set, both bytes first
    wr_reg(ADDR_LCR, 8'h80);
    wr_reg(ADDR_DATA, 8'h03);
    wr_reg(ADDR_IER, 8'h00);
    rd_chk("div_lo", ADDR_DATA, 8'h03);
    rd_chk("div_hi", ADDR_IER, 8'h00);
    baud_gap(n);
    chk("baud_gap", 8'h03, n[7:0]);
    // A long count must not delay a new divisor
    wr_reg(ADDR_IER, 8'h01);
    wr_reg(ADDR_IER, 8'h00);
    n = 0;
    while (baud_out !== 1'b1 && n < 300)
    begin
      tick();
      n++;
    end
    chk_bit("reload", 1'b1, n < 6);
    foreach (PIN_SEQ[i])
    begin
      if (i < 2)
      begin
        wr_reg(ADDR_DATA, i ? 8'h05 : 8'h02);
        baud_gap(n);
        chk("baud_gap", i ? 8'h05 : 8'h02, n[7:0]);
      end
    end
    wr_reg(ADDR_DATA, 8'h03);
    wr_reg(ADDR_LCR, 8'h03);
    // Handshake pins walk with the modem interrupt enabled
    wr_reg(ADDR_IER, 8'h08);
    prev = 4'hF;
    foreach (PIN_SEQ[i])
    begin
      u_modem_peer.set_pins(modem_type'(PIN_SEQ[i]));
      repeat (5) tick();
      dl = ((prev ^ PIN_SEQ[i]) & 4'hB) | (~prev & PIN_SEQ[i] & 4'h4);
      chk_bit("intr_modem", dl != 4'h0, intr);
      rd_chk("msr", ADDR_MSR, {~PIN_SEQ[i], dl});
      rd_chk("msr_clr", ADDR_MSR, {~PIN_SEQ[i], 4'h0});
      prev = PIN_SEQ[i];
    end
    // Loopback: status follows the control bits, pins go inactive
    wr_reg(ADDR_MCR, 8'h11);
    repeat (5) tick();
    rd_reg(ADDR_MSR, d);
    chk("msr_loop", 8'h20, d & 8'hF0);
    chk_bit("dtr_loop", 1'b1, dtr_n);
    wr_reg(ADDR_MCR, 8'h1E);
    repeat (5) tick();
    rd_reg(ADDR_MSR, d);
    chk("msr_loop", 8'hD0, d & 8'hF0);
    wr_reg(ADDR_MCR, 8'h0F);
    tick();
    chk_bit("dtr_on", 1'b0, dtr_n);
    wr_reg(ADDR_MCR, 8'h00);
    repeat (5) tick();
    rd_reg(ADDR_MSR, d);
    // Receive trigger of four
    wr_reg(ADDR_IER, 8'h01);
    wr_reg(ADDR_IIR, 8'h41);
    for (int i = 0; i < 4; i++)
    begin
      u_modem_peer.send({3'h0, 8'h10 + 8'(i)});
      repeat (4) tick();
      chk_bit("intr_trig", i == 3, intr);
    end
    rd_chk("iir_rx", ADDR_IIR, 8'hC4);
    rd_chk("rx", ADDR_DATA, 8'h10);
    repeat (2) tick();
    chk_bit("intr_below", 1'b0, intr);
    // Timeout counted on the receive clock
    u_modem_peer.rclk_on = 1'b1;
    repeat (300) tick();
    chk_bit("tmo_early", 1'b0, intr);
    wait_intr(1'b1, 3000);
    rd_chk("iir_tmo", ADDR_IIR, 8'hCC);
    rd_chk("rx", ADDR_DATA, 8'h11);
    repeat (2) tick();
    chk_bit("tmo_clr", 1'b0, intr);
    repeat (300) tick();
    chk_bit("tmo_restart", 1'b0, intr);
    rd_chk("rx", ADDR_DATA, 8'h12);
    rd_chk("rx", ADDR_DATA, 8'h13);
    rd_reg(ADDR_LSR, d);
    chk_bit("dr_empty", 1'b0, d[0]);
    u_modem_peer.rclk_on = 1'b0;
    // Errored character: line status outranks received data
    wr_reg(ADDR_IIR, 8'h01);
    wr_reg(ADDR_IER, 8'h05);
    u_modem_peer.send({3'h1, 8'h55});
    repeat (4) tick();
    rd_chk("iir_line", ADDR_IIR, 8'hC6);
    rd_reg(ADDR_LSR, d);
    chk("lsr_err", 8'h85, d & 8'h85);
    rd_chk("iir_rx", ADDR_IIR, 8'hC4);
    rd_chk("rx", ADDR_DATA, 8'h55);
    // Polled receive: fill until refused, drain until empty
    wr_reg(ADDR_IER, 8'h00);
    for (int i = 0; i < 16; i++)
      u_modem_peer.send({3'h0, 8'(i)});
    repeat (2) tick();
    chk_bit("rx_full", 1'b0, rx_char_ready);
    chk_bit("intr_poll", 1'b0, intr);
    for (int i = 0; i < 16; i++)
    begin
      rd_reg(ADDR_LSR, d);
      chk_bit("dr_poll", 1'b1, d[0]);
      rd_chk("rx_poll", ADDR_DATA, 8'(i));
    end
    rd_reg(ADDR_LSR, d);
    chk_bit("dr_poll", 1'b0, d[0]);
    // Transmit interrupt, enable change, fill and drain
    wr_reg(ADDR_IER, 8'h02);
    rd_chk("iir_tx_holding_empty_flag", ADDR_IIR, 8'hC2);
    tick();
    chk_bit("tx_holding_empty_flag_clr", 1'b0, intr);
    wr_reg(ADDR_IIR, 8'h00);
    wr_reg(ADDR_IIR, 8'h01);
    repeat (3) tick();
    chk_bit("tx_holding_empty_flag_fcr", 1'b1, intr);
    rd_reg(ADDR_IIR, d);
    u_modem_peer.stall = 1'b1;
    for (int i = 1; i < 4; i++)
      wr_reg(ADDR_DATA, 8'hA0 + 8'(i));
    tick();
    chk_bit("tx_holding_empty_flag_fill", 1'b0, intr);
    rd_reg(ADDR_LSR, d);
    chk_bit("lsr_tx_holding_empty_flag", 1'b0, d[5]);
    u_modem_peer.stall = 1'b0;
    for (int i = 0; i < 500 && (u_modem_peer.got_q.size() < 3 || tx_shift_busy); i++)
      tick();
    for (int i = 0; i < 3; i++)
      chk("tx", 8'hA1 + 8'(i), u_modem_peer.got_q[i]);
    rd_reg(ADDR_LSR, d);
    chk("lsr_tx", 8'h60, d & 8'h60);
    wait_intr(1'b1, 2000);
    rd_chk("iir_tx_holding_empty_flag", ADDR_IIR, 8'hC2);
    tick();
    chk_bit("tx_holding_empty_flag_rd", 1'b0, intr);
    report_and_stop();
  end
endmodule : tb_uart_serial_ctrl
